// [design/kpg_pkg.sv]
// Shared constants for the keypad / GPIO pin configuration block.
// Assumes a single 40 MHz clock and byte-wide registers reached over I2C.
`default_nettype none

package kpg_pkg;

	localparam int CLK_HZ      = 40_000_000;
	localparam int IN_DEB_US   = 50;
	localparam int IN_DEB_CYC  = IN_DEB_US * (CLK_HZ / 1_000_000);
	localparam int SCAN_MS     = 25;
	localparam int SCAN_CYC    = SCAN_MS * (CLK_HZ / 1_000);

	localparam int NUM_ROWS    = 8;
	localparam int NUM_COLS    = 10;
	localparam int NUM_PINS    = 18;
	localparam int NUM_REGS    = 18;

	// Base slot of each three-register group, and the slot of each bypass register
	localparam int G_IE        = 0;
	localparam int G_MS        = 3;
	localparam int G_EM        = 6;
	localparam int G_DIR       = 9;
	localparam int G_POL       = 12;
	localparam int G_BYP_ROWS  = 15;
	localparam int G_BYP_HI    = 16;
	localparam int G_BYP_LO    = 17;

	localparam logic [7:0] REG_OFS [NUM_REGS] = '{
		8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f,
		8'h20, 8'h21, 8'h23, 8'h23, 8'h24, 8'h25,
		8'h26, 8'h27, 8'h28, 8'h29, 8'h2b, 8'h30};
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{
		8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h03,
		8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h03,
		8'hff, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff};
	localparam logic [7:0] REG_RESET = 8'h00;

	localparam logic [7:0] OFS_INT_STAT = 8'h02;
	localparam int         FLAG_BIT     = 1;

	localparam logic [6:0] INPUT_CODE_BASE = 7'h61;
	localparam logic [6:0] KEY_CODE_BASE = 7'h01;

	typedef enum logic [3:0] {
		I_IDLE = 4'h0,
		I_ADDR = 4'h1,
		I_AACK = 4'h2,
		I_WR   = 4'h3,
		I_WACK = 4'h4,
		I_RD   = 4'h5,
		I_MACK = 4'h6
	} kpg_i2c_state_e;

endpackage : kpg_pkg

`default_nettype wire

// [design/kpg_scan_if.sv]
// Signals between the pin configuration top and the matrix scanner.
// Assumes the top owns the mode masks and the filtered row levels.
`default_nettype none

interface kpg_scan_if;
	logic [9:0] col_en;
	logic [7:0] row_en;
	logic [7:0] row_lvl;
	logic [9:0] col_drive;
	logic       ev_valid;
	logic [7:0] ev_code;

	modport scanner (input col_en, row_en, row_lvl,
		output col_drive, ev_valid, ev_code);
	modport host (output col_en, row_en, row_lvl,
		input col_drive, ev_valid, ev_code);
endinterface : kpg_scan_if

`default_nettype wire

// [design/kpg_filter.sv]
// Per-bit input filter: a bit is taken after staying stable, or at once when bypassed.
// Assumes inputs synchronous to ref_clk_in; idle level is high.
`default_nettype none

module kpg_filter #(
	parameter int W   = 19,
	parameter int CYC = kpg_pkg::IN_DEB_CYC
) (
	input  wire logic         ref_clk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] raw_in,
	input  wire logic [W-1:0] bypass_in,
	output logic      [W-1:0] filt_out
);
	localparam int CW = $clog2(CYC + 1);

	for (genvar g = 0; g < W; g++)
	begin : g_bit
		logic [CW-1:0] cnt_q;
		logic [CW-1:0] cnt_d;
		logic          st_q;
		logic          st_d;

		always_comb
		begin
			st_d  = st_q;
			cnt_d = '0;
			if (raw_in[g] != st_q)
			begin
				if (cnt_q == CW'(CYC - 1))
					st_d = raw_in[g];
				else
					cnt_d = cnt_q + CW'(1);
			end
		end

		always_ff @(posedge ref_clk_in)
		begin
			if (!nrst_in)
			begin
				st_q  <= 1'b1;
				cnt_q <= '0;
			end
			else
			begin
				st_q  <= st_d;
				cnt_q <= cnt_d;
			end
		end

		assign filt_out[g] = bypass_in[g] ? raw_in[g] : st_q;
	end

endmodule : kpg_filter

`default_nettype wire

// [design/kpg_scan.sv]
// Key matrix scanner: one column slot at a time, driven only if enabled; reads rows.
// Assumes rows idle high and a pressed key pulls its row low.
`default_nettype none

module kpg_scan #(
	parameter int SLOT_CYC = kpg_pkg::SCAN_CYC / kpg_pkg::NUM_COLS
) (
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	kpg_scan_if.scanner      sif
);
	localparam int CW = $clog2(SLOT_CYC);

	logic [CW-1:0] cnt_q, cnt_d;
	logic [3:0]    col_q, col_d;
	logic [3:0]    pcol_q, pcol_d;
	logic [79:0]   prev_q, prev_d;
	logic [79:0]   stab_q, stab_d;
	logic [7:0]    pend_q, pend_d;
	logic          vld_q, vld_d;
	logic [7:0]    code_q, code_d;
	logic [7:0]    seen;
	logic          found;

	assign seen = ~sif.row_lvl & sif.row_en & {8{sif.col_en[col_q]}};

	always_comb
	begin
		cnt_d  = cnt_q + CW'(1);
		col_d  = col_q;
		pcol_d = pcol_q;
		prev_d = prev_q;
		stab_d = stab_q;
		pend_d = pend_q;
		vld_d  = 1'b0;
		code_d = code_q;
		found  = 1'b0;
		if (cnt_q == CW'(SLOT_CYC - 1))
		begin
			cnt_d  = '0;
			col_d  = (col_q == 4'd9) ? 4'd0 : col_q + 4'd1;
			pcol_d = col_q;
			for (int r = 0; r < 8; r++)
			begin
				// Two matching scans in a row before a change counts
				if (seen[r] == prev_q[r*10 + int'(col_q)] &&
					seen[r] != stab_q[r*10 + int'(col_q)])
				begin
					pend_d[r] = 1'b1;
					stab_d[r*10 + int'(col_q)] = seen[r];
				end
				prev_d[r*10 + int'(col_q)] = seen[r];
			end
		end
		else
		begin
			for (int r = 0; r < 8; r++)
			begin
				if (pend_q[r] && !found)
				begin
					found     = 1'b1;
					pend_d[r] = 1'b0;
					vld_d     = 1'b1;
					code_d    = {stab_q[r*10 + int'(pcol_q)],
						7'(r*10 + int'(pcol_q)) + kpg_pkg::KEY_CODE_BASE};
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!nrst_in)
		begin
			cnt_q  <= '0;
			col_q  <= 4'd0;
			pcol_q <= 4'd0;
			prev_q <= '0;
			stab_q <= '0;
			pend_q <= 8'h00;
			vld_q  <= 1'b0;
			code_q <= 8'h00;
		end
		else
		begin
			cnt_q  <= cnt_d;
			col_q  <= col_d;
			pcol_q <= pcol_d;
			prev_q <= prev_d;
			stab_q <= stab_d;
			pend_q <= pend_d;
			vld_q  <= vld_d;
			code_q <= code_d;
		end
	end

	// Every enabled column gets one slot per scan period
	assign sif.col_drive = sif.col_en & 10'(10'h001 << col_q);
	assign sif.ev_valid  = vld_q;
	assign sif.ev_code   = code_q;

endmodule : kpg_scan

`default_nettype wire

// [design/kpg_pin_config.sv]
// Pin configuration top: I2C register slave, 18 pin modes, input events.
// Assumes SCL/SDA and pins synchronous to ref_clk_in; SDA open drain.
// Functional notes
// - Interrupt enable 1 lets pin change interrupt
// - Enabled input change sets the change flag
// - Interrupt enables act on general inputs only
// - Select bit 0 gives general pin
// - Select bit 1 joins matrix, fixed role
// - Event-mode bit routes input events to key event outputs
// - Direction 0 input, 1 output
// - Polarity 0 falling/low, 1 rising/high
// - Filter-bypass 1 skips input debounce
// - Bypass acts alike on inputs and rows
// - Reset pin always filtered, not disableable
// - Input accepted after stable debounce time
// - Matrix debounce per key, two scans
// - Every column scanned once per period
// - Key accepted after two matching scans
// - Rows bits 7-0, columns 9-0 split
// - Change flag is bit 1, write-1 clear
// - Input events carry codes 97 to 114
`default_nettype none

module kpg_pin_config #(
	parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary value
	parameter int         SCAN_CYC = kpg_pkg::SCAN_CYC
) (
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        ext_reset_n_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	input  wire logic [17:0] pin_in,
	output logic      [17:0] pin_level_out,
	output logic      [17:0] pin_oe_out,
	input  wire logic [17:0] gpio_out_data_in,
	output logic             input_change_flag_out,
	output logic             key_event_valid_out,
	output logic      [7:0]  key_event_code_out
);
	localparam int NR = kpg_pkg::NUM_REGS;
	localparam int NP = kpg_pkg::NUM_PINS;

	kpg_scan_if sif ();

	// Register file
	logic [7:0]  reg_q [NR];
	logic [7:0]  reg_d [NR];
	logic        flag_q, flag_d;
	logic [17:0] ie, ms, em, dir, pol, byp;
	logic [7:0]  rdata;

	// I2C slave
	kpg_pkg::kpg_i2c_state_e st_q, st_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  ptr_q, ptr_d;
	logic        rw_q, rw_d;
	logic        first_q, first_d;
	logic        oe_q, oe_d;
	logic        ack_q, ack_d;
	logic        scl_q, sda_q;
	logic        scl_rise, scl_fall, start, stop;
	logic        wr_stb;

	// Pins and events
	logic [18:0] filt;
	logic        soft_rst;
	logic [17:0] f_q;
	logic [17:0] gen_in, rise, fall, trig, chg;
	logic [17:0] gpend_q, gpend_d;
	logic        kv_q, kv_d;
	logic [7:0]  kc_q, kc_d;
	logic        gfound;

	function automatic logic [17:0] grp(input logic [7:0] lo,
		input logic [7:0] mid, input logic [7:0] hi);
		return {hi[1:0], mid, lo};
	endfunction : grp

	// Group layout: rows 7-0, then columns 7-0, then columns 9-8
	assign ie  = grp(reg_q[kpg_pkg::G_IE], reg_q[kpg_pkg::G_IE+1],
		reg_q[kpg_pkg::G_IE+2]);
	assign ms  = grp(reg_q[kpg_pkg::G_MS], reg_q[kpg_pkg::G_MS+1],
		reg_q[kpg_pkg::G_MS+2]);
	assign em  = grp(reg_q[kpg_pkg::G_EM], reg_q[kpg_pkg::G_EM+1],
		reg_q[kpg_pkg::G_EM+2]);
	assign dir = grp(reg_q[kpg_pkg::G_DIR], reg_q[kpg_pkg::G_DIR+1],
		reg_q[kpg_pkg::G_DIR+2]);
	assign pol = grp(reg_q[kpg_pkg::G_POL], reg_q[kpg_pkg::G_POL+1],
		reg_q[kpg_pkg::G_POL+2]);
	assign byp = grp(reg_q[kpg_pkg::G_BYP_ROWS], reg_q[kpg_pkg::G_BYP_LO],
		reg_q[kpg_pkg::G_BYP_HI]);

	// Reset pin sits on the top filter bit with bypass tied off
	kpg_filter #(
		.W   (NP + 1),
		.CYC (kpg_pkg::IN_DEB_CYC)
	) u_filter (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.raw_in     ({ext_reset_n_in, pin_in}),
		.bypass_in  ({1'b0, byp}),
		.filt_out   (filt)
	);

	assign soft_rst = ~filt[NP];

	kpg_scan #(
		.SLOT_CYC (SCAN_CYC / kpg_pkg::NUM_COLS)
	) u_scan (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.sif        (sif.scanner)
	);

	// Matrix role follows the pin: rows 0-7, columns 8-17
	assign sif.row_en  = ms[7:0];
	assign sif.col_en  = ms[17:8];
	assign sif.row_lvl = filt[7:0];

	// Bus edge detection
	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	assign start    = scl_in & scl_q & sda_q & ~sda_in;
	assign stop     = scl_in & scl_q & ~sda_q & sda_in;

	always_comb
	begin
		rdata = 8'h00;
		if (ptr_q == kpg_pkg::OFS_INT_STAT)
			rdata[kpg_pkg::FLAG_BIT] = flag_q;
		for (int i = 0; i < NR; i++)
			if (ptr_q == kpg_pkg::REG_OFS[i])
				rdata = reg_q[i] & kpg_pkg::REG_MASK[i];
	end

	always_comb
	begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		ptr_d   = ptr_q;
		rw_d    = rw_q;
		first_d = first_q;
		oe_d    = oe_q;
		ack_d   = ack_q;
		wr_stb  = 1'b0;
		if (stop)
		begin
			st_d = kpg_pkg::I_IDLE;
			oe_d = 1'b0;
		end
		else if (start)
		begin
			st_d  = kpg_pkg::I_ADDR;
			cnt_d = 4'd0;
			oe_d  = 1'b0;
		end
		else
		begin
			case (st_q)
				kpg_pkg::I_IDLE: ;
				kpg_pkg::I_ADDR, kpg_pkg::I_WR:
				begin
					if (scl_rise)
					begin
						sh_d  = {sh_q[6:0], sda_in};
						cnt_d = cnt_q + 4'd1;
					end
					else if (scl_fall && cnt_q == 4'd8)
					begin
						cnt_d = 4'd0;
						if (st_q == kpg_pkg::I_WR)
						begin
							oe_d = 1'b1;
							st_d = kpg_pkg::I_WACK;
							if (first_q)
							begin
								ptr_d   = sh_q;
								first_d = 1'b0;
							end
							else
							begin
								wr_stb = 1'b1;
								ptr_d  = ptr_q + 8'h01;
							end
						end
						else if (sh_q[7:1] == DEV_ADDR)
						begin
							st_d    = kpg_pkg::I_AACK;
							oe_d    = 1'b1;
							rw_d    = sh_q[0];
							first_d = 1'b1;
						end
						else
							st_d = kpg_pkg::I_IDLE;
					end
				end
				kpg_pkg::I_AACK:
				begin
					if (scl_fall)
					begin
						if (rw_q)
						begin
							sh_d = rdata;
							oe_d = ~rdata[7];
							st_d = kpg_pkg::I_RD;
						end
						else
						begin
							oe_d = 1'b0;
							st_d = kpg_pkg::I_WR;
						end
					end
				end
				kpg_pkg::I_WACK:
				begin
					if (scl_fall)
					begin
						oe_d = 1'b0;
						st_d = kpg_pkg::I_WR;
					end
				end
				kpg_pkg::I_RD:
				begin
					if (scl_rise)
						cnt_d = cnt_q + 4'd1;
					else if (scl_fall)
					begin
						if (cnt_q == 4'd8)
						begin
							cnt_d = 4'd0;
							oe_d  = 1'b0;
							ptr_d = ptr_q + 8'h01;
							st_d  = kpg_pkg::I_MACK;
						end
						else
						begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = ~sh_q[6];
						end
					end
				end
				kpg_pkg::I_MACK:
				begin
					if (scl_rise)
						ack_d = ~sda_in;
					else if (scl_fall)
					begin
						if (ack_q)
						begin
							sh_d = rdata;
							oe_d = ~rdata[7];
							st_d = kpg_pkg::I_RD;
						end
						else
							st_d = kpg_pkg::I_IDLE;
					end
				end
				default: st_d = kpg_pkg::I_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!nrst_in)
		begin
			st_q    <= kpg_pkg::I_IDLE;
			cnt_q   <= 4'd0;
			sh_q    <= 8'h00;
			ptr_q   <= 8'h00;
			rw_q    <= 1'b0;
			first_q <= 1'b0;
			oe_q    <= 1'b0;
			ack_q   <= 1'b0;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end
		else
		begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			ptr_q   <= ptr_d;
			rw_q    <= rw_d;
			first_q <= first_d;
			oe_q    <= oe_d;
			ack_q   <= ack_d;
			scl_q   <= scl_in;
			sda_q   <= sda_in;
		end
	end

	assign sda_out    = 1'b0;
	assign sda_oe_out = oe_q;

	// Input changes on general input pins only
	assign gen_in = ~ms & ~dir;
	assign rise = filt[17:0] & ~f_q;
	assign fall = ~filt[17:0] & f_q;
	assign trig = (pol & rise) | (~pol & fall);
	assign chg  = (rise | fall) & gen_in & em;

	always_comb
	begin
		for (int i = 0; i < NR; i++)
		begin
			reg_d[i] = reg_q[i];
			if (wr_stb && ptr_q == kpg_pkg::REG_OFS[i])
				reg_d[i] = sh_q & kpg_pkg::REG_MASK[i];
		end
		flag_d = flag_q;
		if (wr_stb && ptr_q == kpg_pkg::OFS_INT_STAT &&
			sh_q[kpg_pkg::FLAG_BIT])
			flag_d = 1'b0;
		// A new change wins over a clear in the same cycle
		if (|(trig & gen_in & ie))
			flag_d = 1'b1;
		gpend_d = gpend_q | chg;
		kv_d    = 1'b0;
		kc_d    = kc_q;
		gfound  = 1'b0;
		if (sif.ev_valid)
		begin
			kv_d = 1'b1;
			kc_d = sif.ev_code;
		end
		else
		begin
			for (int i = 0; i < NP; i++)
			begin
				if (gpend_q[i] && !gfound)
				begin
					gfound     = 1'b1;
					gpend_d[i] = chg[i];
					kv_d       = 1'b1;
					kc_d       = {~(filt[i] ^ pol[i]),
						kpg_pkg::INPUT_CODE_BASE + 7'(i)};
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!nrst_in || soft_rst)
		begin
			for (int i = 0; i < NR; i++)
				reg_q[i] <= kpg_pkg::REG_RESET;
			flag_q  <= 1'b0;
			gpend_q <= '0;
			kv_q    <= 1'b0;
			kc_q    <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < NR; i++)
				reg_q[i] <= reg_d[i];
			flag_q  <= flag_d;
			gpend_q <= gpend_d;
			kv_q    <= kv_d;
			kc_q    <= kc_d;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!nrst_in)
			f_q <= '1;
		else
			f_q <= filt[17:0];
	end

	// Outputs: general outputs drive data, active columns pull low
	assign pin_oe_out = (~ms & dir) | {sif.col_drive, 8'h00};
	assign pin_level_out = ~ms & dir & gpio_out_data_in;
	assign input_change_flag_out = flag_q;
	assign key_event_valid_out   = kv_q;
	assign key_event_code_out    = kc_q;

endmodule : kpg_pin_config

`default_nettype wire

// [bench/kpg_host_model.sv]
// I2C host model: single-byte register writes and reads.
// Assumes SDA is resolved outside with a pull-up; drives on rising edges.
`default_nettype none

module kpg_host_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input  wire logic ref_clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	timeunit 1ns;
	timeprecision 1ns;

	int nack_cnt = 0;

	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	task automatic half();
		repeat (4) @(posedge ref_clk_in);
	endtask : half

	// Data only moves while SCL is low
	task automatic clk_bit(input logic b, output logic r);
		sda_out <= b;
		half();
		scl_out <= 1'b1;
		half();
		r = sda_in;
		scl_out <= 1'b0;
		half();
	endtask : clk_bit

	task automatic start();
		sda_out <= 1'b1;
		half();
		scl_out <= 1'b1;
		half();
		sda_out <= 1'b0;
		half();
		scl_out <= 1'b0;
		half();
	endtask : start

	task automatic stop();
		sda_out <= 1'b0;
		half();
		scl_out <= 1'b1;
		half();
		sda_out <= 1'b1;
		half();
	endtask : stop

	// Ninth bit is always released: a read byte ends in NACK
	task automatic xfer(input logic [7:0] tx, input logic chk,
		output logic [7:0] rx);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(tx[i], r);
			rx[i] = r;
		end
		clk_bit(1'b1, r);
		if (chk && r !== 1'b0)
			nack_cnt++;
	endtask : xfer

	task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
		logic [7:0] rx;
		start();
		xfer({ADDR, 1'b0}, 1'b1, rx);
		xfer(ofs, 1'b1, rx);
		xfer(dat, 1'b1, rx);
		stop();
	endtask : wr

	task automatic rd(input logic [7:0] ofs, output logic [7:0] dat);
		logic [7:0] rx;
		start();
		xfer({ADDR, 1'b0}, 1'b1, rx);
		xfer(ofs, 1'b1, rx);
		start();
		xfer({ADDR, 1'b1}, 1'b1, rx);
		xfer(8'hff, 1'b0, dat);
		stop();
	endtask : rd
endmodule : kpg_host_model

`default_nettype wire

// [bench/kpg_pin_config_properties.sv]
// Port checks of the pin configuration top.
// Assumes one clock domain; bound to every instance of the top.
`default_nettype none

module kpg_props #(
	parameter int SCAN_CYC = kpg_pkg::SCAN_CYC
) (
	input wire logic        ref_clk_in,
	input wire logic        nrst_in,
	input wire logic        ext_reset_n_in,
	input wire logic        scl_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_out,
	input wire logic [17:0] pin_in,
	input wire logic [17:0] pin_level_out,
	input wire logic [17:0] pin_oe_out,
	input wire logic [17:0] gpio_out_data_in,
	input wire logic        input_change_flag_out,
	input wire logic        key_event_valid_out,
	input wire logic [7:0]  key_event_code_out
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int DEB = kpg_pkg::IN_DEB_CYC;
	logic [11:0] quiet_q, quiet_d, ext_lo_q, ext_lo_d;
	logic [17:0] pin_q;

	// Saturating counts: cycles since a pin moved, cycles reset held low
	always_comb
	begin
		quiet_d = (pin_in != pin_q) ? 12'h000
			: quiet_q + {11'h0, quiet_q != 12'hfff};
		ext_lo_d = ext_reset_n_in ? 12'h000
			: ext_lo_q + {11'h0, ext_lo_q != 12'hfff};
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!nrst_in)
		begin
			quiet_q <= 12'h000;
			ext_lo_q <= 12'h000;
			pin_q <= pin_in;
		end
		else
		begin
			quiet_q <= quiet_d;
			ext_lo_q <= ext_lo_d;
			pin_q <= pin_in;
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_ack_start;
		$rose(sda_oe_out);
	endsequence

	sequence s_flag_set;
		!input_change_flag_out ##1 input_change_flag_out;
	endsequence

	a_sda_open_drain: assert property (sda_out == 1'b0)
		else $error("sda data not held low");
	a_ack_scl_low: assert property (s_ack_start |-> !scl_in)
		else $error("sda pulled while scl high");
	a_level_when_driven: assert property (
		(pin_level_out & ~(pin_oe_out & gpio_out_data_in)) == 18'h0)
		else $error("pin level high while not an output one");
	a_rows_not_scanned: assert property (
		(pin_oe_out[7:0] & (pin_level_out[7:0] ^ gpio_out_data_in[7:0]))
		== 8'h00)
		else $error("row pin driven as a scan line");
	a_one_column: assert property (
		$countones(pin_oe_out[17:8] & ~pin_level_out[17:8]
		& gpio_out_data_in[17:8]) <= 1)
		else $error("more than one column scanned");
	a_event_code: assert property (
		key_event_valid_out |-> key_event_code_out[6:0]
		inside {[7'd1:7'd80], [7'd97:7'd114]})
		else $error("event code out of range");
	a_flag_after_change: assert property (
		s_flag_set |-> quiet_q <= 12'(DEB + 4))
		else $error("change flag without recent pin change");
	a_ext_reset_hold: assert property (
		ext_lo_q >= 12'(DEB + 3) |-> pin_oe_out == 18'h0
		&& !input_change_flag_out && !key_event_valid_out)
		else $error("state not cleared by long reset");
endmodule : kpg_props

bind kpg_pin_config kpg_props #(.SCAN_CYC(SCAN_CYC)) u_props (
	.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
	.ext_reset_n_in(ext_reset_n_in), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .pin_in(pin_in),
	.pin_level_out(pin_level_out), .pin_oe_out(pin_oe_out),
	.gpio_out_data_in(gpio_out_data_in),
	.input_change_flag_out(input_change_flag_out),
	.key_event_valid_out(key_event_valid_out),
	.key_event_code_out(key_event_code_out));

`default_nettype wire

// [bench/kpg_pin_config_test.sv]
// Self-checking bench of the pin configuration top.
// Assumes the host model as I2C master; SDA and pins pulled up.
`default_nettype none

module kpg_pin_config_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0;
	logic        nrst, ext_rst_n, scl, sda_host, sda_oe, flag, ev_v;
	logic [17:0] pins, lvl, oe, gdata;
	logic [7:0]  ev_c;
	logic [11:0] ev_sum = 12'h000;
	wire logic   sda_line;
	int          errors = 0, samples_checked = 0, ev_n = 0, cycles = 0;

	assign sda_line = sda_host & ~sda_oe;

	always #12.5 clk = ~clk;

	kpg_host_model host (.ref_clk_in(clk), .sda_in(sda_line),
		.scl_out(scl), .sda_out(sda_host));

	kpg_pin_config #(.SCAN_CYC(200)) dut (.ref_clk_in(clk),
		.nrst_in(nrst), .ext_reset_n_in(ext_rst_n), .scl_in(scl),
		.sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
		.pin_in(pins), .pin_level_out(lvl), .pin_oe_out(oe),
		.gpio_out_data_in(gdata), .input_change_flag_out(flag),
		.key_event_valid_out(ev_v), .key_event_code_out(ev_c));

	always @(posedge clk)
	begin
		cycles++;
		if (ev_v === 1'b1)
		begin
			ev_n++;
			ev_sum += {4'h0, ev_c};
		end
		if (cycles == 60000)
		begin
			errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Checks %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [17:0] exp,
		input logic [17:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt

	task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(ofs, d);
		chk("register", {10'h0, exp}, {10'h0, d});
	endtask : rchk

	task automatic ext_rst(input int n);
		@(posedge clk) ext_rst_n <= 1'b0;
		wt(n);
		@(posedge clk) ext_rst_n <= 1'b1;
		wt(2010);
	endtask : ext_rst

	task automatic t_reset_values();
		for (int i = 0; i < kpg_pkg::NUM_REGS; i++)
			rchk(kpg_pkg::REG_OFS[i], 8'h00);
		rchk(8'h22, 8'h00);
	endtask : t_reset_values

	task automatic t_out_ext();
		host.wr(8'h1a, 8'hff);
		host.wr(8'h1c, 8'hff);
		host.wr(8'h24, 8'hff);
		rchk(8'h1a, 8'hff);
		rchk(8'h1c, 8'h03);
		chk("oe", 18'h0ff00, oe);
		chk("level", 18'h0c300, lvl);
		ext_rst(1000);
		rchk(8'h1a, 8'hff);
		ext_rst(2010);
		chk("oe", 18'h0, oe);
		rchk(8'h1a, 8'h00);
	endtask : t_out_ext

	task automatic t_input();
		host.wr(8'h1a, 8'h01);
		host.wr(8'h20, 8'h03);
		@(posedge clk) pins[2:0] <= 3'b000;
		wt(1990);
		chk("flag", 18'h0, {17'h0, flag});
		wt(20);
		chk("flag", 18'h1, {17'h0, flag});
		rchk(8'h02, 8'h02);
		host.wr(8'h02, 8'h02);
		rchk(8'h02, 8'h00);
		chk("events", 18'd2, 18'(ev_n));
		@(posedge clk) pins[2:0] <= 3'b111;
		wt(2010);
		chk("flag", 18'h0, {17'h0, flag});
		chk("events", 18'd4, 18'(ev_n));
		chk("codes", 18'h286, {6'h0, ev_sum});
	endtask : t_input

	task automatic t_bypass();
		host.wr(8'h26, 8'h08);
		host.wr(8'h1a, 8'h08);
		host.wr(8'h29, 8'h08);
		@(posedge clk) pins[3] <= 1'b0;
		wt(6);
		chk("flag", 18'h0, {17'h0, flag});
		@(posedge clk) pins[3] <= 1'b1;
		wt(6);
		chk("flag", 18'h1, {17'h0, flag});
	endtask : t_bypass

	task automatic t_matrix();
		int          n;
		logic [11:0] s;
		logic [1:0]  saw;
		logic        bad;
		saw = 2'h0;
		bad = 1'b0;
		ext_rst(2010);
		host.wr(8'h1d, 8'h01);
		host.wr(8'h1e, 8'h03);
		host.wr(8'h29, 8'h01);
		host.wr(8'h23, 8'h01);
		host.wr(8'h1a, 8'h01);
		host.wr(8'h20, 8'h01);
		n = ev_n;
		s = ev_sum;
		@(posedge clk) pins[0] <= 1'b0;
		wt(190);
		chk("events", 18'(n), 18'(ev_n));
		for (int i = 0; i < 600; i++)
		begin
			wt(1);
			saw |= oe[9:8];
			bad |= oe[0];
		end
		chk("column", 18'h3, {16'h0, saw});
		chk("row oe", 18'h0, {17'h0, bad});
		chk("events", 18'(n + 2), 18'(ev_n));
		chk("code", 18'h103, {6'h0, 12'(ev_sum - s)});
		chk("flag", 18'h0, {17'h0, flag});
	endtask : t_matrix

	initial
	begin
		nrst <= 1'b0;
		ext_rst_n <= 1'b1;
		pins <= 18'h3ffff;
		gdata <= 18'h3c3c3;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		wt(2);
		t_reset_values();
		t_out_ext();
		t_input();
		t_bypass();
		t_matrix();
		chk("nacks", 18'h0, 18'(host.nack_cnt));
		summarize();
	end
endmodule : kpg_pin_config_test

`default_nettype wire
